// File: include/stc_regs.svh
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// Register indices; byte address is four times the index
`define STC_IDX_CTRL      10'h32C
`define STC_IDX_EXP_LO    10'h32D
`define STC_IDX_EXP_HI    10'h32E
`define STC_IDX_COMP      10'h32F
`define STC_IDX_INV       10'h334
`define STC_IDX_IRQ_STAT  10'h340
`define STC_IDX_IRQ_MASK  10'h341
`define STC_IDX_COUNT     10'h342

// Field positions
`define STC_CTRL_SLOT_LSB 4
`define STC_CTRL_CHAN_LSB 2
`define STC_CTRL_CLR_BIT  1
`define STC_CTRL_EN_BIT   0
`define STC_COMP_IQ_BIT   6
`define STC_COMP_FAIL_BIT 0
`define STC_IRQ_FAIL_BIT  0
`define STC_IRQ_MATCH_BIT 1

// Values
`define STC_RST_BYTE      8'h00
`define STC_CHAN_NONE     2'h3
`define STC_COMP_RW_MASK  8'hFE

`endif

// File: include/stc_pkg.sv
package stc_pkg;

  typedef logic [15:0] stc_sample_t;
  // Index 0 is the in-phase part, index 1 the quadrature part
  typedef stc_sample_t [1:0] stc_iq_t;
  typedef stc_iq_t [15:0] stc_slots_t;
  typedef stc_slots_t [2:0] stc_tpl_t;

  typedef struct packed {
    stc_tpl_t samples;
    logic     valid;
  } stc_tpl_bus_t;

  typedef logic [31:0] stc_lane_word_t;
  typedef stc_lane_word_t [7:0] stc_lanes_t;

  typedef enum logic {
    STC_CHK_IDLE,
    STC_CHK_RUN
  } stc_chk_t;

  typedef struct packed {
    logic [3:0] slot;
    logic [1:0] chan;
    logic       clr;
    logic       en;
  } stc_ctrl_t;

  typedef struct packed {
    stc_ctrl_t   ctrl;
    logic [7:0]  exp_lo;
    logic [7:0]  exp_hi;
    logic [7:0]  comp;
    logic [7:0]  inv;
    logic        fail;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [15:0] cmp_cnt;
    logic [15:0] err_cnt;
    stc_chk_t    chk;
    logic        sel_valid;
    stc_sample_t sel_sample;
    logic [31:0] prdata;
    logic        slverr;
  } stc_state_t;

  typedef struct packed {
    stc_lanes_t lanes;
  } stc_inv_state_t;

endpackage

// File: verilog/stc_lane_invert.sv
`include "stc_regs.svh"

module stc_lane_invert (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          invert_mask,
  input  wire stc_pkg::stc_lanes_t lane_in,
  output stc_pkg::stc_lanes_t      lane_out
);

  stc_pkg::stc_inv_state_t s_reg;
  stc_pkg::stc_inv_state_t s_next;
  stc_pkg::stc_lanes_t     flipped;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lane
      assign flipped[g] = invert_mask[g] ? ~lane_in[g] : lane_in[g]; // [R10]
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.lanes = flipped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lane_out = s_reg.lanes;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lane_flip_a: assert property ( // [R10]
    invert_mask[0] |=> lane_out[0] == ~$past(lane_in[0]))
    else $error("lane 0 not inverted");

  lane_pass_a: assert property ( // [R10]
    !invert_mask[7] |=> lane_out[7] == $past(lane_in[7]))
    else $error("lane 7 altered");

endmodule

// File: verilog/stc_checker.sv
// Summary of operation
// [R01] - Control bits 7:4 pick which sample slot, 0 to 15, gets checked.
// [R02] - Control bits 3:2 pick channel 0, 1 or 2 under test.
// [R03] - While control bit 1 is one, the test result is cleared.
// [R04] - Comparison runs only while control bit 0 enables the checker.
// [R05] - Expected sample low byte comes from register 0x32D.
// [R06] - Expected sample high byte comes from register 0x32E.
// [R07] - Bit 6 of 0x32F picks in-phase (0) or quadrature (1) part.
// [R08] - Comparison uses samples straight from the receiver transport output.
// [R09] - Bit 0 of 0x32F reads zero on match, one on mismatch.
// [R10] - Lane x data is inverted while bit x of 0x334 is one.
// [R11] - A mismatch keeps the fail flag set until the test is cleared.
// [R12] - Transmitter repeats the constant sample while the test runs.
`include "stc_regs.svh"

module stc_checker (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire stc_pkg::stc_tpl_bus_t tpl_in,
  input  wire stc_pkg::stc_lanes_t   lane_raw,
  output stc_pkg::stc_lanes_t        lane_out,
  output logic                       mismatch_flag,
  output logic                       irq
);

  stc_pkg::stc_state_t  s_reg;
  stc_pkg::stc_state_t  s_next;
  logic [9:0]           idx;
  logic                 setup;
  logic                 access;
  logic                 wr;
  logic                 hit;
  logic [31:0]          rd_word;
  logic [1:0]           ch_idx;
  logic                 chan_ok;
  logic                 iq_sel;
  stc_pkg::stc_sample_t pick;
  logic [15:0]          expected;
  logic                 diff;
  logic                 same;
  logic                 ev_fail;
  logic                 ev_match;
  logic [1:0]           events;

  assign idx    = paddr[11:2];
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr     = access & pwrite & hit;

  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (idx)
      `STC_IDX_CTRL: begin
        rd_word[7:0] = s_reg.ctrl;
      end
      `STC_IDX_EXP_LO: begin
        rd_word[7:0] = s_reg.exp_lo;
      end
      `STC_IDX_EXP_HI: begin
        rd_word[7:0] = s_reg.exp_hi;
      end
      `STC_IDX_COMP: begin
        rd_word[7:0] = s_reg.comp & `STC_COMP_RW_MASK;
        rd_word[`STC_COMP_FAIL_BIT] = s_reg.fail; // [R09]
      end
      `STC_IDX_INV: begin
        rd_word[7:0] = s_reg.inv;
      end
      `STC_IDX_IRQ_STAT: begin
        rd_word[1:0] = s_reg.irq_stat;
      end
      `STC_IDX_IRQ_MASK: begin
        rd_word[1:0] = s_reg.irq_mask;
      end
      `STC_IDX_COUNT: begin
        rd_word = {s_reg.err_cnt, s_reg.cmp_cnt};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Code 11 names no channel; index kept in range anyway
  assign chan_ok = s_reg.ctrl.chan != `STC_CHAN_NONE; // [R02]
  assign ch_idx  = chan_ok ? s_reg.ctrl.chan : 2'h0;
  assign iq_sel  = s_reg.comp[`STC_COMP_IQ_BIT]; // [R07]
  // Taken at the transport output, before any later datapath stage
  assign pick = tpl_in.samples[ch_idx][s_reg.ctrl.slot][iq_sel]; // [R01] [R08]
  assign expected = {s_reg.exp_hi, s_reg.exp_lo}; // [R05] [R06]

  // Compared one cycle after capture to keep the wide mux off this path
  assign diff     = s_reg.sel_valid & (s_reg.sel_sample != expected);
  assign same     = s_reg.sel_valid & (s_reg.sel_sample == expected);
  assign ev_fail  = diff & ~s_reg.fail & ~s_reg.ctrl.clr;
  assign ev_match = same;
  assign events[`STC_IRQ_FAIL_BIT]  = ev_fail;
  assign events[`STC_IRQ_MATCH_BIT] = ev_match;

  always_comb begin
    s_next = s_reg;

    if (setup) begin
      s_next.prdata = rd_word;
      s_next.slverr = ~hit;
    end

    if (wr) begin
      case (idx)
        `STC_IDX_CTRL: begin
          s_next.ctrl = stc_pkg::stc_ctrl_t'(pwdata[7:0]);
        end
        `STC_IDX_EXP_LO: begin
          s_next.exp_lo = pwdata[7:0]; // [R05]
        end
        `STC_IDX_EXP_HI: begin
          s_next.exp_hi = pwdata[7:0]; // [R06]
        end
        `STC_IDX_COMP: begin
          s_next.comp = pwdata[7:0] & `STC_COMP_RW_MASK;
        end
        `STC_IDX_INV: begin
          s_next.inv = pwdata[7:0]; // [R10]
        end
        `STC_IDX_IRQ_STAT: begin
          s_next.irq_stat = s_reg.irq_stat & ~pwdata[1:0];
        end
        `STC_IDX_IRQ_MASK: begin
          s_next.irq_mask = pwdata[1:0];
        end
        default: begin
          s_next.slverr = s_reg.slverr;
        end
      endcase
    end

    // Set after the clear so a coincident event is kept
    s_next.irq_stat = s_next.irq_stat | events;

    case (s_reg.chk)
      stc_pkg::STC_CHK_IDLE: begin
        if (s_reg.ctrl.en && chan_ok) begin // [R04]
          s_next.chk = stc_pkg::STC_CHK_RUN;
        end
      end
      stc_pkg::STC_CHK_RUN: begin
        if (!s_reg.ctrl.en || !chan_ok) begin // [R04]
          s_next.chk = stc_pkg::STC_CHK_IDLE;
        end
      end
      default: begin
        s_next.chk = stc_pkg::STC_CHK_IDLE;
      end
    endcase

    s_next.sel_valid = (s_reg.chk == stc_pkg::STC_CHK_RUN)
                       & s_reg.ctrl.en & chan_ok & tpl_in.valid; // [R04]
    s_next.sel_sample = pick; // [R01] [R07]

    if (s_reg.sel_valid) begin
      s_next.cmp_cnt = s_reg.cmp_cnt + 16'h0001;
    end
    if (diff) begin
      s_next.err_cnt = s_reg.err_cnt + 16'h0001;
      s_next.fail = 1'b1; // [R09] [R11]
    end

    // Level clear beats a same-cycle mismatch: the test is held in reset
    if (s_reg.ctrl.clr) begin
      s_next.fail    = 1'b0; // [R03]
      s_next.cmp_cnt = 16'h0000;
      s_next.err_cnt = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  stc_lane_invert u_lane_invert (
    .pclk        (pclk),
    .presetn     (presetn),
    .invert_mask (s_reg.inv),
    .lane_in     (lane_raw),
    .lane_out    (lane_out)
  );

  assign prdata        = s_reg.prdata;
  assign pready        = access;
  assign pslverr       = access & s_reg.slverr;
  assign mismatch_flag = s_reg.fail;
  assign irq           = |(s_reg.irq_stat & s_reg.irq_mask);

  // Helpers read only by the checks below
  stc_pkg::stc_sample_t chk_slot5_i;
  stc_pkg::stc_sample_t chk_ch1_q;
  logic [3:0]           chk_slot;
  logic [1:0]           chk_chan;
  logic                 chk_iq;
  logic                 chk_run;
  assign chk_slot5_i = tpl_in.samples[0][5][0];
  assign chk_ch1_q   = tpl_in.samples[1][s_reg.ctrl.slot][1];
  assign chk_slot    = s_reg.ctrl.slot;
  assign chk_chan    = s_reg.ctrl.chan;
  assign chk_iq      = s_reg.comp[`STC_COMP_IQ_BIT];
  assign chk_run     = s_reg.chk == stc_pkg::STC_CHK_RUN;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  slot_pick_a: assert property ( // [R01]
    chk_run && s_reg.ctrl.en && tpl_in.valid && chk_slot == 4'h5
    && chk_chan == 2'h0 && !chk_iq
    |=> s_reg.sel_valid && s_reg.sel_sample == $past(chk_slot5_i))
    else $error("slot 5 sample not captured");

  chan_none_a: assert property ( // [R02]
    chk_chan == `STC_CHAN_NONE |=> !s_reg.sel_valid && !chk_run)
    else $error("channel 3 still compared");

  clear_result_a: assert property ( // [R03]
    s_reg.ctrl.clr |=> !mismatch_flag && s_reg.err_cnt == 16'h0000)
    else $error("test clear did not clear result");

  enable_gate_a: assert property ( // [R04]
    !s_reg.ctrl.en |=> !s_reg.sel_valid && !chk_run)
    else $error("comparison ran while disabled");

  expected_cmp_a: assert property ( // [R05] [R06]
    s_reg.sel_valid && s_reg.sel_sample != {s_reg.exp_hi, s_reg.exp_lo}
    && !s_reg.ctrl.clr |=> mismatch_flag)
    else $error("mismatch against expected not flagged");

  quad_pick_a: assert property ( // [R07]
    chk_run && s_reg.ctrl.en && tpl_in.valid && chk_chan == 2'h1
    && chk_iq |=> s_reg.sel_sample == $past(chk_ch1_q))
    else $error("quadrature part not selected");

  transport_src_a: assert property ( // [R08]
    s_reg.sel_valid |-> $past(tpl_in.valid) && $past(chk_run))
    else $error("compare without transport sample");

  result_read_a: assert property ( // [R09]
    setup && idx == `STC_IDX_COMP
    |=> prdata[`STC_COMP_FAIL_BIT] == $past(s_reg.fail))
    else $error("fail bit read back wrong");

  fail_sticky_a: assert property ( // [R11]
    mismatch_flag && !s_reg.ctrl.clr |=> mismatch_flag)
    else $error("fail flag dropped without clear");

  irq_fail_a: assert property (
    ev_fail && s_reg.irq_mask[`STC_IRQ_FAIL_BIT] && !wr |=> irq)
    else $error("fail interrupt not raised");

endmodule

// File: test/stc_tx_model.sv
module stc_tx_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [15:0]      base,
  input  wire logic             run,
  output stc_pkg::stc_tpl_bus_t tpl,
  output stc_pkg::stc_lanes_t   lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each position carries its own value so a wrong slot pick shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpl <= '0;
      lanes <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        for (int s = 0; s < 16; s++) begin
          for (int q = 0; q < 2; q++) begin
            if (run) begin
              tpl.samples[c][s][q] <= base + 16'({2'(c), 4'(s), 1'(q)});
            end else begin
              tpl.samples[c][s][q] <= ~tpl.samples[c][s][q];
            end
          end
        end
      end
      tpl.valid <= run;
      for (int x = 0; x < 8; x++) begin
        lanes[x] <= {base, 8'(x), 8'h5A};
      end
    end
  end
endmodule

// File: test/short_transport_test_checker_tb.sv
`include "stc_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module short_transport_test_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  slot;
    logic [1:0]  chan;
    logic        iq;
    logic [15:0] delta;
    logic        fail;
  } stc_row_t;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic                  pready, pslverr, mismatch_flag, irq, tx_run;
  logic                  rerr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rdata;
  logic [15:0]           tx_base, expv;
  stc_pkg::stc_tpl_bus_t tpl;
  stc_pkg::stc_lanes_t   lane_raw, lane_out;
  int                    err_count, compares, cycles;
  stc_row_t              rows [7] = '{'{0, 0, 0, 0, 0}, '{15, 2, 1, 0, 0},
    '{7, 1, 0, 1, 1}, '{3, 2, 0, 16'h8000, 1}, '{9, 0, 1, 16'h0100, 1},
    '{12, 1, 1, 0, 0}, '{5, 0, 0, 0, 0}};

  stc_checker dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tpl_in(tpl),
    .lane_raw(lane_raw), .lane_out(lane_out),
    .mismatch_flag(mismatch_flag), .irq(irq));
  stc_tx_model tx_u (.pclk(pclk), .presetn(presetn), .base(tx_base),
    .run(tx_run), .tpl(tpl), .lanes(lane_raw));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 32'(d));
  endtask

  task automatic rd(input logic [9:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    tx_run = 1'b1;
    tx_base = 16'h1234;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      expv = tx_base + 16'({rows[i].chan, rows[i].slot, rows[i].iq})
             + rows[i].delta;
      wr(`STC_IDX_CTRL, {rows[i].slot, rows[i].chan, 2'b10});
      wr(`STC_IDX_COMP, {1'b0, rows[i].iq, 6'h00});
      wr(`STC_IDX_EXP_LO, expv[7:0]);
      wr(`STC_IDX_EXP_HI, expv[15:8]);
      wr(`STC_IDX_CTRL, {rows[i].slot, rows[i].chan, 2'b01});
      wait_cyc(8);
      rd(`STC_IDX_COMP);
      `CHK(rdata, 32'({1'b0, rows[i].iq, 5'h00, rows[i].fail}))
      `CHK(mismatch_flag, rows[i].fail)
      rd(`STC_IDX_EXP_HI);
      `CHK(rdata, 32'(expv[15:8]))
      $display("row %0d done", i);
    end
    // Enable off: a wrong expected value must not be flagged
    wr(`STC_IDX_CTRL, 8'h02);
    wr(`STC_IDX_EXP_LO, 8'hFF);
    wr(`STC_IDX_CTRL, 8'h00);
    wait_cyc(8);
    `CHK(mismatch_flag, 1'b0)
    $display("disable test done");
    // Sticky fail, then interrupt mask and clear
    wr(`STC_IDX_COMP, 8'h00);
    wr(`STC_IDX_CTRL, 8'h01);
    wait_cyc(8);
    `CHK(mismatch_flag, 1'b1)
    wr(`STC_IDX_EXP_LO, tx_base[7:0]);
    wr(`STC_IDX_EXP_HI, tx_base[15:8]);
    wait_cyc(8);
    `CHK(mismatch_flag, 1'b1)
    wr(`STC_IDX_IRQ_MASK, 8'h00);
    `CHK(irq, 1'b0)
    wr(`STC_IDX_IRQ_MASK, 8'h01);
    wait_cyc(1);
    `CHK(irq, 1'b1)
    wr(`STC_IDX_CTRL, 8'h02);
    wait_cyc(2);
    `CHK(mismatch_flag, 1'b0)
    wr(`STC_IDX_IRQ_STAT, 8'h03);
    wait_cyc(1);
    `CHK(irq, 1'b0)
    rd(`STC_IDX_IRQ_STAT);
    `CHK(rdata, 32'h0000_0000)
    $display("sticky test done");
    // Channel code 3 never compares; a later failure then raises irq
    wr(`STC_IDX_EXP_LO, 8'hFF);
    wr(`STC_IDX_CTRL, 8'h0D);
    wait_cyc(8);
    `CHK(mismatch_flag, 1'b0)
    wr(`STC_IDX_CTRL, 8'h01);
    wait_cyc(8);
    `CHK(irq, 1'b1)
    `CHK(mismatch_flag, 1'b1)
    rd(`STC_IDX_COUNT);
    `CHK(rdata, 32'h0007_0007)
    $display("channel none test done");
    // Unmapped index
    rd(10'h330);
    `CHK({rerr, rdata}, 33'h1_0000_0000)
    // Lane inversion per mask bit
    wr(`STC_IDX_INV, 8'hA5);
    wait_cyc(3);
    for (int x = 0; x < 8; x++) begin
      `CHK(lane_out[x], ((8'hA5 >> x) & 1) ? ~lane_raw[x] : lane_raw[x])
    end
    $display("lane test done");
    // Mid-run reset returns the control, expected, compare and invert registers to zero
    presetn <= 1'b0;
    wait_cyc(3);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      rd(10'(`STC_IDX_CTRL + i));
      `CHK(rdata, 32'h0000_0000)
    end
    rd(`STC_IDX_INV);
    `CHK(rdata, 32'h0000_0000)
    $display("reset test done");
    close_out();
  end
endmodule
